// >>> write_stream_dma_params.sv
// Streaming DMA write command decode, time limit and ending status
`timescale 1ns/1ps

// Operation
// - Urgent flag: finish fast and always inside the completion time limit.
// - Continue-on-error flag: errors never abort the command.
// - Continue on error: move full amount, end fault set, log error type.
// - Continue on error and limit expiry: stop, fault set, log overrun.
// - Always try to move the whole amount before the limit expires.
// - Flush flag: write buffered stream data to media before completion.
// - Resume flag: start at last error address and resume recovery.
// - Limit in microseconds equals previous feature byte times identify unit.
// - Zero limit value uses the stored stream default limit.
// - Zero or missing default means the limit is ignored.
// - Limit measured from command write to final completion interrupt.
// - Sector count is 16 bits; zero means 65,536 sectors.
// - Command code 3A written after parameter registers starts command.
// - Stream fault status bit 5 set on error with continue-on-error.
// - Overrun bit 0 of error register set when limit exceeded.
module write_stream_dma_params
   import stream_write_pkg::*;
(
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset,
   // Task-file write port from the host
   input  wire logic        i_tf_write,
   input  wire logic [2:0]  i_tf_sel,
   input  wire logic [7:0]  i_tf_data,
   // Drive configuration
   input  wire logic [31:0] i_time_unit_us,
   input  wire logic        i_cfg_write,
   input  wire logic [2:0]  i_cfg_stream,
   input  wire logic [7:0]  i_cfg_default_limit,
   input  wire logic [2:0]  i_stream_id,
   // Data path events
   input  wire logic        i_sector_done,
   input  wire logic        i_crc_error,
   input  wire logic        i_idnf_error,
   input  wire logic        i_abort_error,
   input  wire logic        i_flush_done,
   // Decoded command to the data path
   output logic             o_xfer_active,
   output logic [16:0]      o_sector_total,
   output logic [47:0]      o_start_lba,
   output logic             o_urgent_flag,
   output logic             o_resume_after_error,
   output logic             o_flush_request,
   // Ending status
   output logic [7:0]       o_status,
   output logic [7:0]       o_error,
   output logic [7:0]       o_error_log,
   output logic             o_intrq
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Zero count stands for the full 65,536 sectors
   function automatic logic [16:0] sector_total(input logic [15:0] cnt);
      sector_total = (cnt == 16'h0000) ? FULL_COUNT : {1'b0, cnt};
   endfunction

   // Limit in clock ticks; sized wide so the product never wraps
   function automatic logic [47:0] limit_ticks(input logic [7:0] val,
                                                input logic [31:0] unit);
      limit_ticks = 48'(val) * 48'(unit) * 48'(TICKS_PER_US);
   endfunction

   // ----------------------------------------------------------------
   // Parameter byte pairs: a write shifts current into previous
   // ----------------------------------------------------------------
   logic [7:0] feat_cur, feat_prev, cnt_cur, cnt_prev;
   logic [7:0] sec_cur, sec_prev, cyl_lo_cur, cyl_lo_prev, cyl_hi_cur, cyl_hi_prev;
   logic [7:0] next_feat_cur, next_feat_prev, next_cnt_cur, next_cnt_prev;
   logic [7:0] next_sec_cur, next_sec_prev, next_cyl_lo_cur, next_cyl_lo_prev;
   logic [7:0] next_cyl_hi_cur, next_cyl_hi_prev;

   always_comb begin
      next_feat_cur    = feat_cur;
      next_feat_prev   = feat_prev;
      next_cnt_cur     = cnt_cur;
      next_cnt_prev    = cnt_prev;
      next_sec_cur     = sec_cur;
      next_sec_prev    = sec_prev;
      next_cyl_lo_cur  = cyl_lo_cur;
      next_cyl_lo_prev = cyl_lo_prev;
      next_cyl_hi_cur  = cyl_hi_cur;
      next_cyl_hi_prev = cyl_hi_prev;
      if (i_tf_write) begin
         case (i_tf_sel)
            SEL_FEATURE: begin
               next_feat_prev = feat_cur;
               next_feat_cur  = i_tf_data;
            end
            SEL_COUNT: begin
               next_cnt_prev = cnt_cur;
               next_cnt_cur  = i_tf_data;
            end
            SEL_SECTOR: begin
               next_sec_prev = sec_cur;
               next_sec_cur  = i_tf_data;
            end
            SEL_CYL_LOW: begin
               next_cyl_lo_prev = cyl_lo_cur;
               next_cyl_lo_cur  = i_tf_data;
            end
            SEL_CYL_HIGH: begin
               next_cyl_hi_prev = cyl_hi_cur;
               next_cyl_hi_cur  = i_tf_data;
            end
            default: begin
            end
         endcase
      end
   end

   // Byte pairs register as two packed groups
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         {feat_cur, feat_prev, cnt_cur, cnt_prev, sec_cur} <= '0;
         {sec_prev, cyl_lo_cur, cyl_lo_prev, cyl_hi_cur, cyl_hi_prev} <= '0;
      end else begin
         {feat_cur, feat_prev, cnt_cur, cnt_prev, sec_cur} <=
            {next_feat_cur, next_feat_prev, next_cnt_cur, next_cnt_prev, next_sec_cur};
         {sec_prev, cyl_lo_cur, cyl_lo_prev, cyl_hi_cur, cyl_hi_prev} <=
            {next_sec_prev, next_cyl_lo_cur, next_cyl_lo_prev, next_cyl_hi_cur, next_cyl_hi_prev};
      end
   end

   // ----------------------------------------------------------------
   // Per-stream default limits stored by stream configuration
   // ----------------------------------------------------------------
   logic [7:0] default_limit [STREAM_IDS];
   logic       default_valid [STREAM_IDS];

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         for (int i = 0; i < STREAM_IDS; i++) begin
            default_limit[i] <= BYTE_ZERO;
            default_valid[i] <= 1'b0;
         end
      end else if (i_cfg_write) begin
         default_limit[i_cfg_stream] <= i_cfg_default_limit;
         default_valid[i_cfg_stream] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   cmd_state_t  state, next_state;
   logic        start_cmd;
   logic [7:0]  limit_val;
   logic        limit_on, next_limit_on;
   logic [47:0] limit_cnt, next_limit_cnt;
   logic [16:0] remaining, next_remaining;
   logic        expired;
   logic [7:0]  next_status, next_error, next_error_log;
   logic        next_intrq, next_active, next_flush_request;
   logic        next_urgent, next_resume;
   logic [16:0] next_total;
   logic [47:0] next_lba;
   logic        any_err;

   assign start_cmd = i_tf_write && (i_tf_sel == SEL_COMMAND)
                      && (i_tf_data == CMD_WRITE_STREAM_DMA) && (state == ST_IDLE);
   // Zero value falls back to the stream default; zero default disables
   assign limit_val = (feat_prev != BYTE_ZERO) ? feat_prev :
                      (default_valid[i_stream_id] ? default_limit[i_stream_id] : BYTE_ZERO);
   assign expired   = limit_on && (limit_cnt == 48'h0000_0000_0000);
   assign any_err   = i_crc_error || i_idnf_error || i_abort_error;

   always_comb begin
      next_state         = state;
      next_limit_on      = limit_on;
      next_limit_cnt     = limit_cnt;
      next_remaining     = remaining;
      next_status        = o_status;
      next_error         = o_error;
      next_error_log     = o_error_log;
      next_intrq         = 1'b0;
      next_active        = o_xfer_active;
      next_flush_request = o_flush_request;
      next_urgent        = o_urgent_flag;
      next_resume        = o_resume_after_error;
      next_total         = o_sector_total;
      next_lba           = o_start_lba;
      // Timer runs from command write until the completion interrupt
      if (limit_on && !expired) begin
         next_limit_cnt = limit_cnt - 48'h0000_0000_0001;
      end
      case (state)
         ST_IDLE: begin
            if (start_cmd) begin
               next_total  = sector_total({cnt_prev, cnt_cur});
               next_remaining = sector_total({cnt_prev, cnt_cur});
               next_lba = {cyl_hi_prev, cyl_lo_prev, sec_prev,
                           cyl_hi_cur, cyl_lo_cur, sec_cur};
               next_urgent = feat_cur[URGENT_BIT];
               next_resume = feat_cur[RESUME_BIT];
               next_limit_on  = (limit_val != BYTE_ZERO);
               next_limit_cnt = limit_ticks(limit_val, i_time_unit_us);
               next_active = 1'b1;
               next_error  = BYTE_ZERO;
               next_error_log = BYTE_ZERO;
               next_status = BYTE_ZERO;
               next_status[STAT_BUSY_BIT] = 1'b1;
               next_state  = ST_XFER;
            end
         end
         ST_XFER: begin
            // Errors are logged; only without continue-on-error do they abort
            if (any_err) begin
               next_error_log[ERR_CRC_BIT]   = o_error_log[ERR_CRC_BIT] | i_crc_error;
               next_error_log[ERR_IDNF_BIT]  = o_error_log[ERR_IDNF_BIT] | i_idnf_error;
               next_error_log[ERR_ABORT_BIT] = o_error_log[ERR_ABORT_BIT] | i_abort_error;
            end
            if (expired) begin
               next_error_log[ERR_OVERRUN_BIT] = 1'b1;
               next_active = 1'b0;
               next_state  = ST_DONE;
            end else if (any_err && !feat_cur[CONTINUE_BIT]) begin
               next_active = 1'b0;
               next_state  = ST_DONE;
            end else if (i_sector_done) begin
               // Keep going to the full amount despite errors
               next_remaining = remaining - 17'h0_0001;
               if (remaining == 17'h0_0001) begin
                  next_active = 1'b0;
                  next_flush_request = feat_cur[FLUSH_BIT];
                  next_state = feat_cur[FLUSH_BIT] ? ST_FLUSH : ST_DONE;
               end
            end
         end
         ST_FLUSH: begin
            if (expired) begin
               next_error_log[ERR_OVERRUN_BIT] = 1'b1;
               next_flush_request = 1'b0;
               next_state = ST_DONE;
            end else if (i_flush_done) begin
               next_flush_request = 1'b0;
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // Ending status: fault instead of error when continuing on error
            next_status = BYTE_ZERO;
            next_status[STAT_READY_BIT] = 1'b1;
            if (o_error_log != BYTE_ZERO) begin
               if (feat_cur[CONTINUE_BIT]) begin
                  next_status[STAT_FAULT_BIT] = 1'b1;
               end else begin
                  next_status[STAT_ERR_BIT] = 1'b1;
                  next_error = o_error_log;
               end
            end
            next_error[ERR_OVERRUN_BIT] = o_error_log[ERR_OVERRUN_BIT];
            next_intrq    = 1'b1;
            next_limit_on = 1'b0;
            next_state    = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state                <= ST_IDLE;
         limit_on             <= 1'b0;
         limit_cnt            <= 48'h0000_0000_0000;
         remaining            <= 17'h0_0000;
         o_status             <= BYTE_ZERO;
         o_error              <= BYTE_ZERO;
         o_error_log          <= BYTE_ZERO;
         o_intrq              <= 1'b0;
         o_xfer_active        <= 1'b0;
         o_flush_request      <= 1'b0;
         o_urgent_flag        <= 1'b0;
         o_resume_after_error <= 1'b0;
         o_sector_total       <= 17'h0_0000;
         o_start_lba          <= 48'h0000_0000_0000;
      end else begin
         state                <= next_state;
         limit_on             <= next_limit_on;
         limit_cnt            <= next_limit_cnt;
         remaining            <= next_remaining;
         o_status             <= next_status;
         o_error              <= next_error;
         o_error_log          <= next_error_log;
         o_intrq              <= next_intrq;
         o_xfer_active        <= next_active;
         o_flush_request      <= next_flush_request;
         o_urgent_flag        <= next_urgent;
         o_resume_after_error <= next_resume;
         o_sector_total       <= next_total;
         o_start_lba          <= next_lba;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence cmd_write_s;
      start_cmd;
   endsequence
   sequence busy_s;
      o_status[STAT_BUSY_BIT] && o_xfer_active;
   endsequence

   a_cmd_starts_busy: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      cmd_write_s |=> busy_s)
      else $error("command write did not start transfer");
   a_zero_count_full: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (start_cmd && cnt_cur == BYTE_ZERO && cnt_prev == BYTE_ZERO) |=> o_sector_total == FULL_COUNT)
      else $error("zero count not full");
   a_lba_assembly: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      start_cmd |=> o_start_lba[31:24] == $past(sec_prev) && o_start_lba[7:0] == $past(sec_cur))
      else $error("address bytes misplaced");
   a_fault_no_err: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (o_intrq && o_status[STAT_FAULT_BIT]) |-> !o_status[STAT_ERR_BIT])
      else $error("fault with error bit");
   a_overrun_stops: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (state == ST_XFER && expired) |=> !o_xfer_active ##1 o_intrq)
      else $error("expiry did not stop command");
   a_overrun_flag: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (state == ST_XFER && expired) |=> o_error_log[ERR_OVERRUN_BIT] ##1 o_error[ERR_OVERRUN_BIT])
      else $error("overrun not flagged");
   a_continue_errors: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (state == ST_XFER && any_err && feat_cur[CONTINUE_BIT] && !expired && !i_sector_done)
      |=> state == ST_XFER)
      else $error("error aborted continuing command");
   a_no_limit_idle: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (start_cmd && limit_val == BYTE_ZERO) |=> !limit_on [*2])
      else $error("limit armed with zero value");
   a_flush_first: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (state == ST_FLUSH && !i_flush_done && !expired) |=> !o_intrq && state == ST_FLUSH)
      else $error("completion before flush");

endmodule

// >>> stream_write_pkg.sv
// Shared constants for the streaming DMA write command interpreter
package stream_write_pkg;

   // ----------------------------------------------------------------
   // Task-file register selects
   // ----------------------------------------------------------------
   localparam logic [2:0] SEL_FEATURE   = 3'h1;
   localparam logic [2:0] SEL_COUNT     = 3'h2;
   localparam logic [2:0] SEL_SECTOR    = 3'h3;
   localparam logic [2:0] SEL_CYL_LOW   = 3'h4;
   localparam logic [2:0] SEL_CYL_HIGH  = 3'h5;
   localparam logic [2:0] SEL_COMMAND   = 3'h7;

   // ----------------------------------------------------------------
   // Command code and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_STREAM_DMA = 8'h3A;
   localparam int         URGENT_BIT           = 7;
   localparam int         CONTINUE_BIT         = 6;
   localparam int         FLUSH_BIT            = 5;
   localparam int         RESUME_BIT           = 4;
   localparam int         STAT_BUSY_BIT        = 7;
   localparam int         STAT_READY_BIT       = 6;
   localparam int         STAT_FAULT_BIT       = 5;
   localparam int         STAT_ERR_BIT         = 0;
   localparam int         ERR_CRC_BIT          = 7;
   localparam int         ERR_IDNF_BIT         = 4;
   localparam int         ERR_ABORT_BIT        = 2;
   localparam int         ERR_OVERRUN_BIT      = 0;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [16:0] FULL_COUNT    = 17'h1_0000;
   localparam int          CLK_MHZ       = 100;
   localparam logic [6:0]  TICKS_PER_US  = 7'(CLK_MHZ);
   localparam int          STREAM_IDS    = 8;

   // Command sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_XFER,
      ST_FLUSH,
      ST_DONE
   } cmd_state_t;

endpackage

// >>> host_task_file_model.sv
// Host controller model that loads task-file registers and issues commands
`timescale 1ns/1ps
module host_task_file_model
   import stream_write_pkg::*;
(
   // Clock
   input  wire logic       i_sys_clk,
   // Task-file write port toward the device
   output logic            o_tf_write,
   output logic [2:0]      o_tf_sel,
   output logic [7:0]      o_tf_data
);
   // Bus starts idle
   initial begin
      o_tf_write = 1'b0;
      o_tf_sel   = 3'h0;
      o_tf_data  = 8'h00;
   end

   // One strobe; idle bus shows the inverse so stale data is never trusted
   task automatic put(input logic [2:0] sel, input logic [7:0] data);
      @(negedge i_sys_clk);
      o_tf_write = 1'b1;
      o_tf_sel   = sel;
      o_tf_data  = data;
      @(negedge i_sys_clk);
      o_tf_write = 1'b0;
      o_tf_sel   = ~sel;
      o_tf_data  = ~data;
   endtask

   // Parameters first, previous byte before current, command byte last
   task automatic issue(input logic [7:0] flags, input logic [7:0] limit,
                        input logic [15:0] count, input logic [47:0] lba,
                        input logic [7:0] code);
      put(SEL_FEATURE, limit);
      put(SEL_FEATURE, flags);
      put(SEL_COUNT, count[15:8]);
      put(SEL_COUNT, count[7:0]);
      put(SEL_SECTOR, lba[31:24]);
      put(SEL_SECTOR, lba[7:0]);
      put(SEL_CYL_LOW, lba[39:32]);
      put(SEL_CYL_LOW, lba[15:8]);
      put(SEL_CYL_HIGH, lba[47:40]);
      put(SEL_CYL_HIGH, lba[23:16]);
      put(SEL_COMMAND, code);
   endtask
endmodule

// >>> tb_write_stream_dma_params.sv
// Self-checking testbench for the streaming write command interpreter
`timescale 1ns/1ps
module tb_write_stream_dma_params;
   import stream_write_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        i_sys_clk = 1'b0;
   logic        i_reset = 1'b1;
   logic        tf_write;
   logic [2:0]  tf_sel;
   logic [7:0]  tf_data;
   logic [31:0] time_unit = 32'h0000_0001;
   logic        cfg_write = 1'b0;
   logic [2:0]  cfg_stream = 3'h0;
   logic [7:0]  cfg_limit = 8'h00;
   logic [2:0]  stream_id = 3'h7;
   logic        sector_done = 1'b0;
   logic [2:0]  err = 3'h0;
   logic        flush_done = 1'b0;
   logic        o_xfer_active;
   logic [16:0] o_sector_total;
   logic [47:0] o_start_lba;
   logic        o_urgent_flag;
   logic        o_resume_after_error;
   logic        o_flush_request;
   logic [7:0]  o_status;
   logic [7:0]  o_error;
   logic [7:0]  o_error_log;
   logic        o_intrq;
   int          n_errors = 0;
   int          tests_run = 0;
   localparam logic [47:0] LBA = 48'h0605_0403_0201;

   // 100 MHz clock
   always #5 i_sys_clk = ~i_sys_clk;

   // ----------------------------------------------------------------
   // Instances
   // ----------------------------------------------------------------
   host_task_file_model u_host (
      .i_sys_clk (i_sys_clk),
      .o_tf_write(tf_write),
      .o_tf_sel  (tf_sel),
      .o_tf_data (tf_data)
   );

   write_stream_dma_params u_dut (
      .i_sys_clk           (i_sys_clk),
      .i_reset             (i_reset),
      .i_tf_write          (tf_write),
      .i_tf_sel            (tf_sel),
      .i_tf_data           (tf_data),
      .i_time_unit_us      (time_unit),
      .i_cfg_write         (cfg_write),
      .i_cfg_stream        (cfg_stream),
      .i_cfg_default_limit (cfg_limit),
      .i_stream_id         (stream_id),
      .i_sector_done       (sector_done),
      .i_crc_error         (err[2]),
      .i_idnf_error        (err[1]),
      .i_abort_error       (err[0]),
      .i_flush_done        (flush_done),
      .o_xfer_active       (o_xfer_active),
      .o_sector_total      (o_sector_total),
      .o_start_lba         (o_start_lba),
      .o_urgent_flag       (o_urgent_flag),
      .o_resume_after_error(o_resume_after_error),
      .o_flush_request     (o_flush_request),
      .o_status            (o_status),
      .o_error             (o_error),
      .o_error_log         (o_error_log),
      .o_intrq             (o_intrq)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (n_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Sector pulses spaced by an idle cycle
   task automatic sectors(input int n);
      repeat (n) begin
         @(negedge i_sys_clk);
         sector_done = 1'b1;
         @(negedge i_sys_clk);
         sector_done = 1'b0;
      end
   endtask

   // Error pulse: crc, idnf, abort
   task automatic err_pulse(input logic [2:0] e);
      @(negedge i_sys_clk);
      err = e;
      @(negedge i_sys_clk);
      err = 3'h0;
   endtask

   // Issue then step past the acceptance edge
   task automatic start(input logic [7:0] flags, input logic [7:0] limit,
                        input logic [15:0] count);
      u_host.issue(flags, limit, count, LBA, CMD_WRITE_STREAM_DMA);
      @(negedge i_sys_clk);
      check(o_xfer_active, 1'b1);
   endtask

   // Bounded wait for completion, then the ending registers
   task automatic ending(input logic [7:0] s, input logic [7:0] e, input logic [7:0] l);
      int k;
      k = 0;
      while (o_intrq !== 1'b1 && k < 300) begin
         @(negedge i_sys_clk);
         k++;
      end
      check(o_intrq, 1'b1);
      check(o_status, s);
      check(o_error, e);
      check(o_error_log, l);
      @(negedge i_sys_clk);
      check(o_intrq, 1'b0);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(negedge i_sys_clk);
      i_reset = 1'b0;
      check(o_status, 8'h00);
      // Plain command with urgent and resume flags, no limit on stream 7
      start(8'h90, 8'h00, 16'h0003);
      check(o_status[STAT_BUSY_BIT], 1'b1);
      check(o_sector_total, 17'h0_0003);
      check(o_start_lba, LBA);
      check(o_urgent_flag, 1'b1);
      check(o_resume_after_error, 1'b1);
      sectors(3);
      ending(8'h40, 8'h00, 8'h00);
      // Other command code is ignored
      u_host.issue(8'h00, 8'h00, 16'h0001, LBA, 8'h3B);
      repeat (3) @(negedge i_sys_clk);
      check(o_xfer_active, 1'b0);
      // Zero count, limit 1 x 2 us = 200 cycles, expires under continue
      time_unit = 32'h0000_0002;
      start(8'h40, 8'h01, 16'h0000);
      check(o_sector_total, 17'h1_0000);
      repeat (190) @(negedge i_sys_clk);
      check(o_xfer_active, 1'b1);
      // Limit of 200 cycles from the command edge stops the transfer
      repeat (10) @(negedge i_sys_clk);
      check(o_xfer_active, 1'b0);
      ending(8'h60, 8'h01, 8'h01);
      check(o_error[ERR_OVERRUN_BIT], 1'b1);
      // Errors under continue do not stop the transfer
      start(8'h40, 8'h00, 16'h0002);
      check(o_urgent_flag, 1'b0);
      check(o_resume_after_error, 1'b0);
      err_pulse(3'b111);
      check(o_xfer_active, 1'b1);
      sectors(2);
      ending(8'h60, 8'h00, 8'h94);
      check(o_status[STAT_FAULT_BIT], 1'b1);
      // Error without continue ends with the error bit
      start(8'h00, 8'h00, 16'h0005);
      err_pulse(3'b100);
      ending(8'h41, 8'h80, 8'h80);
      // Flush holds completion until the stream is on the media
      start(8'h20, 8'h00, 16'h0001);
      sectors(1);
      repeat (4) @(negedge i_sys_clk);
      check(o_flush_request, 1'b1);
      check(o_intrq, 1'b0);
      flush_done = 1'b1;
      @(negedge i_sys_clk);
      flush_done = 1'b0;
      ending(8'h40, 8'h00, 8'h00);
      check(o_flush_request, 1'b0);
      // Zero limit takes the stored default of stream 2: 1 x 1 us
      time_unit = 32'h0000_0001;
      cfg_stream = 3'h2;
      cfg_limit = 8'h01;
      cfg_write = 1'b1;
      @(negedge i_sys_clk);
      cfg_write = 1'b0;
      stream_id = 3'h2;
      start(8'h40, 8'h00, 16'h0004);
      repeat (85) @(negedge i_sys_clk);
      check(o_xfer_active, 1'b1);
      // Default limit of 100 cycles stops the transfer
      repeat (15) @(negedge i_sys_clk);
      check(o_xfer_active, 1'b0);
      ending(8'h60, 8'h01, 8'h01);
      // Stream 3 stores a zero default, so no limit applies
      cfg_stream = 3'h3;
      cfg_limit = 8'h00;
      cfg_write = 1'b1;
      @(negedge i_sys_clk);
      cfg_write = 1'b0;
      stream_id = 3'h3;
      start(8'h40, 8'h00, 16'h0001);
      repeat (300) @(negedge i_sys_clk);
      check(o_xfer_active, 1'b1);
      sectors(1);
      ending(8'h40, 8'h00, 8'h00);
      finish_test();
   end

   // Watchdog well beyond the fewer than one thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      n_errors++;
      finish_test();
   end
endmodule
